// [src/sfrc_ctrl.sv]
// What this block does
// - The switch is turned off whenever thermal shutdown or current limit triggers.
// - A protection trigger while on or retrying moves the block into a fault state that holds the switch off.
// - In the fault state the fault indication is presented on the sense output.
// - Switch and indication are released only with latch low, retry delay expired, no fault.
// - A thermal fault is flagged on the absolute or on the relative temperature threshold.
// - An absolute thermal fault holds until the temperature falls by the hysteresis.
// - A relative thermal fault clears once the retry delay has elapsed.
// - A registered current-limit event switches the output off at once, then waits out the retry delay.
// - An over-current event registers only after the limit is exceeded for 3 us.
// - With latch held high the switch stays off after a shutdown until latch goes low.
// - With latch low the switch retries by itself once faults clear and the delay expires.
// - During a retry the indication stays until the output is near the supply.
// - With foldback on, seven consecutive shutdowns halve the limit until standby or a clean cycle.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module sfrc_ctrl
   import sfrc_pkg::*;
#(
   parameter int RETRY_CYC = RETRY_CYC_DEF
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Control pins from the system controller
   input wire logic enable_in,
   input wire logic latch_mode_in,
   input wire logic diagnostic_enable,
   // Analog comparators
   input wire logic abs_temp_over,
   input wire logic abs_temp_clear,
   input wire logic rel_temp_over,
   input wire logic current_limit_hit,
   input wire logic out_near_supply,
   // Power stage and sense output
   output logic switch_on,
   output logic fault_sense_current,
   output logic load_sense_on,
   output logic half_current_limit,
   // Interrupt
   output logic irq
);

   localparam int TMR_W = $clog2(RETRY_CYC + 1);

   logic [PIN_W-1:0] pin_s1_reg;
   logic [PIN_W-1:0] pin_s2_reg;
   logic en_s;
   logic latch_s;
   logic diag_s;
   logic abs_s;
   logic abs_clr_s;
   logic rel_s;
   logic cur_s;
   logic near_s;
   logic [DEGLITCH_W-1:0] oc_cnt_reg;
   logic oc_hit;
   logic abs_flt_reg;
   logic rel_flt_reg;
   logic ocl_flt_reg;
   logic any_trig;
   logic flags_any;
   logic release_ok;
   sfrc_state_t state_reg;
   sfrc_state_t state_next;
   logic fault_entry;
   logic clean_off;
   logic [FOLD_W-1:0] fold_cnt_reg;
   logic half_reg;
   logic fold_en_reg;
   logic switch_on_reg;
   logic fault_ind_reg;
   logic load_sense_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [IRQ_W-1:0] irq_ev;
   logic [IRQ_W-1:0] irq_clr;
   logic [DATA_W-1:0] rdata_reg;
   sfrc_status_t status;

   sfrc_tmr_if #(.W(TMR_W)) tmr_bus ();

   sfrc_retry_timer #(.W(TMR_W)) u_timer (
      .sys_clk(sys_clk),
      .srst(srst),
      .tb(tmr_bus.timer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_s1_reg <= PIN_RST;
         pin_s2_reg <= PIN_RST;
      end else begin
         pin_s1_reg <= {out_near_supply, current_limit_hit, rel_temp_over, abs_temp_clear,
                        abs_temp_over, diagnostic_enable, latch_mode_in, enable_in};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   assign en_s = pin_s2_reg[PIN_EN];
   assign latch_s = pin_s2_reg[PIN_LATCH];
   assign diag_s = pin_s2_reg[PIN_DIAG];
   assign abs_s = pin_s2_reg[PIN_ABS_OVER];
   assign abs_clr_s = pin_s2_reg[PIN_ABS_CLR];
   assign rel_s = pin_s2_reg[PIN_REL_OVER];
   assign cur_s = pin_s2_reg[PIN_CUR_HIT];
   assign near_s = pin_s2_reg[PIN_NEAR_SUP];

   ////////////////////////////////////////////////////////////////////////////
   // Over-current deglitch filter

   // Short spikes from load steps must not trip the switch
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         oc_cnt_reg <= '0;
      end else if (!cur_s) begin
         oc_cnt_reg <= '0;
      end else if (oc_cnt_reg != DEGLITCH_W'(DEGLITCH_CYC)) begin
         oc_cnt_reg <= oc_cnt_reg + DEGLITCH_W'(1);
      end
   end

   assign oc_hit = cur_s && (oc_cnt_reg == DEGLITCH_W'(DEGLITCH_CYC));

   ////////////////////////////////////////////////////////////////////////////
   // Fault flags; a new trigger always wins over a clear

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         abs_flt_reg <= 1'b0;
      end else if (abs_s) begin
         abs_flt_reg <= 1'b1;
      end else if (abs_clr_s) begin
         abs_flt_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rel_flt_reg <= 1'b0;
      end else if (rel_s) begin
         rel_flt_reg <= 1'b1;
      end else if (tmr_bus.expired) begin
         rel_flt_reg <= 1'b0;
      end
   end

   // Switch is already off, so the current fault only waits for the delay
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ocl_flt_reg <= 1'b0;
      end else if (oc_hit) begin
         ocl_flt_reg <= 1'b1;
      end else if (tmr_bus.expired) begin
         ocl_flt_reg <= 1'b0;
      end
   end

   assign any_trig = abs_s || rel_s || oc_hit;
   assign flags_any = abs_flt_reg || rel_flt_reg || ocl_flt_reg;
   assign release_ok = !latch_s && tmr_bus.expired && !flags_any && !any_trig;

   ////////////////////////////////////////////////////////////////////////////
   // Switch state machine

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (en_s && !flags_any && !any_trig) begin
               state_next = ST_ON;
            end
         end
         ST_ON: begin
            if (any_trig) begin
               state_next = ST_FAULT;
            end else if (!en_s) begin
               state_next = ST_OFF;
            end
         end
         ST_FAULT: begin
            if (release_ok) begin
               state_next = en_s ? ST_RETRY : ST_OFF;
            end
         end
         ST_RETRY: begin
            if (any_trig) begin
               state_next = ST_FAULT;
            end else if (!en_s) begin
               state_next = ST_OFF;
            end else if (near_s) begin
               state_next = ST_ON;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_reg <= ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign fault_entry = (state_reg != ST_FAULT) && (state_next == ST_FAULT);
   assign clean_off = (state_reg == ST_ON) && (state_next == ST_OFF);

   // Timer restarts on each shutdown, never while already held off
   assign tmr_bus.start = fault_entry;
   assign tmr_bus.load = TMR_W'(RETRY_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all taken from the next state so they turn with the state

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         switch_on_reg <= 1'b0;
         fault_ind_reg <= 1'b0;
         load_sense_reg <= 1'b0;
      end else begin
         switch_on_reg <= (state_next == ST_ON) || (state_next == ST_RETRY);
         fault_ind_reg <= (state_next == ST_FAULT) || (state_next == ST_RETRY);
         load_sense_reg <= diag_s && (state_next == ST_ON);
      end
   end

   assign switch_on = switch_on_reg;
   assign fault_sense_current = fault_ind_reg;
   assign load_sense_on = load_sense_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Current limit foldback

   // Standby or a fault-free on-off cycle restores the full limit
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fold_cnt_reg <= '0;
         half_reg <= 1'b0;
      end else if (fault_entry) begin
         if (fold_cnt_reg != FOLD_W'(FOLD_COUNT)) begin
            fold_cnt_reg <= fold_cnt_reg + FOLD_W'(1);
         end
         if (fold_en_reg && (fold_cnt_reg == FOLD_W'(FOLD_COUNT - 1))) begin
            half_reg <= 1'b1;
         end
      end else if (clean_off || (state_reg == ST_OFF)) begin
         fold_cnt_reg <= '0;
         half_reg <= 1'b0;
      end
   end

   assign half_current_limit = half_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Register port

   assign irq_clr = (reg_wr && reg_addr == REG_IRQ_CLR) ? reg_wdata[IRQ_W-1:0] : '0;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fold_en_reg <= CTRL_FOLD_RST;
         irq_en_reg <= IRQ_RST;
      end else if (reg_wr) begin
         if (reg_addr == REG_CTRL) begin
            fold_en_reg <= reg_wdata[CTRL_FOLD_BIT];
         end
         if (reg_addr == REG_IRQ_EN) begin
            irq_en_reg <= reg_wdata[IRQ_W-1:0];
         end
      end
   end

   assign irq_ev[IRQ_FAULT] = fault_entry;
   assign irq_ev[IRQ_RETRY_OK] = (state_reg == ST_RETRY) && (state_next == ST_ON);
   assign irq_ev[IRQ_FOLD] = fault_entry && fold_en_reg && !half_reg
                             && (fold_cnt_reg == FOLD_W'(FOLD_COUNT - 1));

   // A new event in the clearing cycle survives
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_stat_reg <= IRQ_RST;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   always_comb begin
      status = '0;
      status.switch_on = switch_on_reg;
      status.state = state_reg;
      status.abs_flt = abs_flt_reg;
      status.rel_flt = rel_flt_reg;
      status.ocl_flt = ocl_flt_reg;
      status.half_limit = half_reg;
      status.fold_cnt = fold_cnt_reg;
   end

   // Unmapped and write-only offsets read as zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: rdata_reg <= DATA_W'(fold_en_reg);
            REG_STATUS: rdata_reg <= status;
            REG_IRQ_STAT: rdata_reg <= DATA_W'(irq_stat_reg);
            REG_IRQ_EN: rdata_reg <= DATA_W'(irq_en_reg);
            default: rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   sequence s_on_tripped;
      state_reg == ST_ON && any_trig;
   endsequence

   sequence s_held_off;
      state_reg == ST_FAULT && !switch_on_reg;
   endsequence

   sequence s_cur_rise;
      !cur_s ##1 cur_s [*8];
   endsequence

   sequence s_ready_release;
      state_reg == ST_FAULT && !latch_s && tmr_bus.expired && !flags_any && !any_trig;
   endsequence

   a_trip_switch_off: assert property (
      s_on_tripped |=> s_held_off)
      else $error("trip did not turn the switch off");

   a_fault_holds_off: assert property (
      state_reg == ST_FAULT |-> !switch_on_reg && !$rose(switch_on_reg))
      else $error("switch driven while in fault");

   a_fault_indicated: assert property (
      s_on_tripped |=> fault_ind_reg [*2])
      else $error("fault indication missing");

   a_release_blocked: assert property (
      (state_reg == ST_FAULT && (!tmr_bus.expired || flags_any)) |=> state_reg == ST_FAULT)
      else $error("fault left before all conditions held");

   a_latch_holds: assert property (
      (state_reg == ST_FAULT && latch_s) |=> !switch_on_reg && fault_ind_reg)
      else $error("latch high did not hold the switch off");

   a_abs_flag_holds: assert property (
      (abs_flt_reg && !abs_clr_s) |=> abs_flt_reg)
      else $error("absolute thermal fault dropped early");

   a_abs_rel_detect: assert property (
      (abs_s || rel_s) |=> (abs_flt_reg || rel_flt_reg))
      else $error("thermal fault not flagged");

   a_rel_clear_retry: assert property (
      (rel_flt_reg && !rel_s && tmr_bus.expired) |=> !rel_flt_reg)
      else $error("relative thermal fault not cleared after delay");

   a_oc_deglitch: assert property (
      s_cur_rise |-> !oc_hit)
      else $error("over-current registered before filter time");

   a_oc_immediate: assert property (
      (oc_hit && state_reg == ST_ON) |=> !switch_on_reg ##0 state_reg == ST_FAULT)
      else $error("current limit did not switch off at once");

   a_auto_retry: assert property (
      (s_ready_release ##0 en_s) |=> state_reg == ST_RETRY && switch_on_reg)
      else $error("no automatic retry");

   a_retry_flag_kept: assert property (
      (state_reg == ST_RETRY && !near_s && en_s && !any_trig) |=> fault_ind_reg)
      else $error("fault indication cleared before output rose");

   a_fold_halves: assert property (
      (fault_entry && fold_en_reg && fold_cnt_reg == FOLD_W'(FOLD_COUNT - 1))
      |=> half_reg)
      else $error("foldback did not halve the limit");

   a_timer_start: assert property (
      fault_entry |=> !tmr_bus.expired [*2])
      else $error("retry timer not started at shutdown");

endmodule // sfrc_ctrl

`default_nettype wire

// [src/sfrc_pkg.sv]
package sfrc_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register offsets (byte addresses, one word each)
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h10;

   // Control register fields and reset value
   localparam int CTRL_FOLD_BIT = 0;
   localparam logic CTRL_FOLD_RST = 1'h0;

   // Interrupt sources
   localparam int IRQ_W = 3;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_RETRY_OK = 1;
   localparam int IRQ_FOLD = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // Pin sample vector layout
   localparam int PIN_W = 8;
   localparam int PIN_EN = 0;
   localparam int PIN_LATCH = 1;
   localparam int PIN_DIAG = 2;
   localparam int PIN_ABS_OVER = 3;
   localparam int PIN_ABS_CLR = 4;
   localparam int PIN_REL_OVER = 5;
   localparam int PIN_CUR_HIT = 6;
   localparam int PIN_NEAR_SUP = 7;
   localparam logic [PIN_W-1:0] PIN_RST = 8'h00;

   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int DEGLITCH_NS = 3000;
   localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEGLITCH_W = $clog2(DEGLITCH_CYC + 1);
   localparam int RETRY_CYC_DEF = 25000;

   // Foldback
   localparam int FOLD_COUNT = 7;
   localparam int FOLD_W = 3;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_ON = 2'b01,
      ST_FAULT = 2'b10,
      ST_RETRY = 2'b11
   } sfrc_state_t;

   typedef struct packed {
      logic [21:0] rsvd;
      logic [FOLD_W-1:0] fold_cnt;
      logic half_limit;
      logic ocl_flt;
      logic rel_flt;
      logic abs_flt;
      logic [1:0] state;
      logic switch_on;
   } sfrc_status_t;

endpackage

// [src/sfrc_tmr_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface sfrc_tmr_if #(parameter int W = 16);
   logic start;
   logic [W-1:0] load;
   logic expired;
   modport owner (output start, output load, input expired);
   modport timer (input start, input load, output expired);
endinterface // sfrc_tmr_if

`default_nettype wire

// [src/sfrc_retry_timer.sv]
`timescale 1ns/10ps
`default_nettype none

module sfrc_retry_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Timer side of the interface
   sfrc_tmr_if.timer tb
);

   logic [W-1:0] cnt_reg;
   logic expired_reg;

   // Restart wins over a running count
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_reg <= '0;
      end else if (tb.start) begin
         cnt_reg <= tb.load;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - W'(1);
      end
   end

   // Idle timer reads expired so nothing waits on it after reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         expired_reg <= 1'b1;
      end else if (tb.start) begin
         expired_reg <= 1'b0;
      end else if (cnt_reg == W'(1)) begin
         expired_reg <= 1'b1;
      end
   end

   assign tb.expired = expired_reg;

endmodule // sfrc_retry_timer

`default_nettype wire

// [verification/sfrc_mcu_model.sv]
`timescale 1ns/10ps
`default_nettype none

module sfrc_mcu_model (
   // Clock
   input wire logic sys_clk,
   // Control pins toward the switch
   output logic enable_in,
   output logic latch_mode_in,
   output logic diagnostic_enable
);
   initial begin
      enable_in = 1'h0;
      latch_mode_in = 1'h0;
      diagnostic_enable = 1'h0;
   end

   // Pins move only just after an edge, as a port write of the controller would
   task automatic set_pins(input logic en, input logic latch, input logic diag);
      @(posedge sys_clk);
      enable_in <= en;
      latch_mode_in <= latch;
      diagnostic_enable <= diag;
   endtask
endmodule // sfrc_mcu_model

`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb
   import sfrc_pkg::*;
;
   localparam int RETRY = 20;
   localparam int LIMIT_CYC = 20000;
   // Row: abs, rel, cur, latch, then expected ocl, rel, abs flags
   localparam logic [6:0] ROWS [5] = '{7'h14, 7'h22, 7'h41, 7'h1c, 7'h6b};

   logic sys_clk = 1'h0;
   logic srst = 1'h1;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 32'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [DATA_W-1:0] reg_rdata;
   logic enable_in;
   logic latch_mode_in;
   logic diagnostic_enable;
   logic abs_temp_over = 1'h0;
   logic abs_temp_clear = 1'h1;
   logic rel_temp_over = 1'h0;
   logic current_limit_hit = 1'h0;
   logic out_near_supply = 1'h0;
   logic switch_on;
   logic fault_sense_current;
   logic load_sense_on;
   logic half_current_limit;
   logic irq;
   logic [DATA_W-1:0] rd_val;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   int cnt;

   always #20 sys_clk = ~sys_clk;

   sfrc_mcu_model mcu (.sys_clk(sys_clk), .enable_in(enable_in),
      .latch_mode_in(latch_mode_in), .diagnostic_enable(diagnostic_enable));

   sfrc_ctrl #(.RETRY_CYC(RETRY)) uut (.sys_clk(sys_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .enable_in(enable_in), .latch_mode_in(latch_mode_in),
      .diagnostic_enable(diagnostic_enable), .abs_temp_over(abs_temp_over),
      .abs_temp_clear(abs_temp_clear), .rel_temp_over(rel_temp_over),
      .current_limit_hit(current_limit_hit), .out_near_supply(out_near_supply),
      .switch_on(switch_on), .fault_sense_current(fault_sense_current),
      .load_sense_on(load_sense_on), .half_current_limit(half_current_limit), .irq(irq));

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                        input string what);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1;
      d = reg_rdata;
   endtask

   // Bounded wait on switch_on (w = 0) or fault_sense_current (w = 1)
   task automatic wait_for(input int w, input logic v, input int lim);
      cnt = 0;
      while (((w == 0) ? switch_on : fault_sense_current) !== v && cnt < lim) begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end
   endtask

   // One protection trip from ON, then release and recovery through RETRY
   task automatic trip(input logic [6:0] r);
      mcu.set_pins(1'h1, r[3], 1'h1);
      wait_for(0, 1'h1, 10);
      @(posedge sys_clk);
      abs_temp_over <= r[6];
      abs_temp_clear <= ~r[6];
      rel_temp_over <= r[5];
      current_limit_hit <= r[4];
      wait_for(0, 1'h0, 100);
      check(switch_on, 1'h0, "switch off on trip");
      check(fault_sense_current, 1'h1, "fault indication");
      rd(REG_STATUS, rd_val);
      check(rd_val[5:3], r[2:0], "fault flags");
      check(rd_val[2:1], ST_FAULT, "fault state");
      @(posedge sys_clk);
      out_near_supply <= 1'h0;
      abs_temp_over <= 1'h0;
      rel_temp_over <= 1'h0;
      current_limit_hit <= 1'h0;
      repeat (RETRY - 8) @(posedge sys_clk);
      #1;
      check(switch_on, 1'h0, "held off before delay");
      repeat (RETRY + 8) @(posedge sys_clk);
      #1;
      check(switch_on, !(r[3] | r[6]), "release");
      mcu.set_pins(1'h1, 1'h0, 1'h1);
      abs_temp_clear <= 1'h1;
      wait_for(0, 1'h1, RETRY + 10);
      check(fault_sense_current, 1'h1, "indication kept in retry");
      @(posedge sys_clk);
      out_near_supply <= 1'h1;
      wait_for(1, 1'h0, 10);
      check(switch_on, 1'h1, "switch back on");
      check(load_sense_on, 1'h1, "load sensing resumed");
   endtask

   ////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT_CYC) begin
         mismatches++;
         $display("ERROR at %0t: run too long", $time);
         summarize();
      end
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      srst <= 1'h0;
      #1;
      check(switch_on, 1'h0, "switch after reset");
      check(fault_sense_current, 1'h0, "indication after reset");
      rd(REG_CTRL, rd_val);
      check(rd_val, 32'h0, "ctrl reset value");
      rd(REG_IRQ_EN, rd_val);
      check(rd_val, 32'h0, "irq enable reset value");
      rd(8'h40, rd_val);
      check(rd_val, 32'h0, "unmapped read");
      rd(REG_IRQ_CLR, rd_val);
      check(rd_val, 32'h0, "write-only read");
      wr(REG_IRQ_EN, 32'h1);
      $display("done: reset and registers");

      for (int i = 0; i < 5; i++) begin
         trip(ROWS[i]);
      end
      $display("done: fault table");

      rd(REG_IRQ_STAT, rd_val);
      check(rd_val, 32'h3, "irq status after faults");
      check(irq, 1'h1, "irq raised");
      wr(REG_IRQ_EN, 32'h0);
      check(irq, 1'h0, "irq masked");
      wr(REG_IRQ_EN, 32'h1);
      check(irq, 1'h1, "irq unmasked");
      wr(REG_IRQ_CLR, 32'h7);
      check(irq, 1'h0, "irq cleared");
      $display("done: interrupt mask and clear");

      // A 70-cycle burst is shorter than the filter, a held level trips
      @(posedge sys_clk);
      current_limit_hit <= 1'h1;
      repeat (70) @(posedge sys_clk);
      current_limit_hit <= 1'h0;
      repeat (5) @(posedge sys_clk);
      #1;
      check(switch_on, 1'h1, "short burst filtered");
      @(posedge sys_clk);
      current_limit_hit <= 1'h1;
      wait_for(0, 1'h0, 100);
      // Two synchroniser stages, the full filter count, then one edge to switch off
      check(cnt, DEGLITCH_CYC + 3, "current trip delay");
      $display("done: current filter");

      // Reset in mid-fault must drop everything at once; enable drops with it
      mcu.set_pins(1'h0, 1'h0, 1'h1);
      srst <= 1'h1;
      current_limit_hit <= 1'h0;
      repeat (3) @(posedge sys_clk);
      #1;
      check(switch_on, 1'h0, "switch in reset");
      check(fault_sense_current, 1'h0, "indication in reset");
      check(irq, 1'h0, "irq in reset");
      @(posedge sys_clk);
      srst <= 1'h0;
      $display("done: reset in fault");

      mcu.set_pins(1'h0, 1'h0, 1'h1);
      repeat (5) @(posedge sys_clk);
      wr(REG_CTRL, 32'h1);
      rd(REG_CTRL, rd_val);
      check(rd_val, 32'h1, "ctrl readback");
      for (int i = 1; i <= FOLD_COUNT; i++) begin
         trip(ROWS[0]);
         check(half_current_limit, 1'(i == FOLD_COUNT), "limit halving");
      end
      rd(REG_IRQ_STAT, rd_val);
      check(rd_val[IRQ_FOLD], 1'h1, "foldback event");
      mcu.set_pins(1'h0, 1'h0, 1'h1);
      repeat (5) @(posedge sys_clk);
      #1;
      check(half_current_limit, 1'h0, "limit restored");
      check(load_sense_on, 1'h0, "no load sense when off");
      $display("done: foldback");

      // Load sensing needs the diagnostic pin even with the switch on
      mcu.set_pins(1'h1, 1'h0, 1'h0);
      repeat (5) @(posedge sys_clk);
      #1;
      check(switch_on, 1'h1, "switch on without diagnostics");
      check(load_sense_on, 1'h0, "load sense gated by diagnostics");
      check(fault_sense_current, 1'h0, "no indication without fault");
      $display("done: diagnostic gating");
      summarize();
   end
endmodule // tb

`default_nettype wire
